/* File: can_filt_pkg.sv */
// Package with register map, field layouts and carriers for the filter block.
package can_filt_pkg;
	localparam int NUM_FILTERS = 16;
	localparam int NUM_BUFFERS = 8;
	localparam int NUM_PAIRS = 4;
	localparam int ID_WIDTH = 16;
	// Byte offsets of the register map.
	localparam logic [11:0] FILTER_VALUE_BASE = 12'h0_000;
	localparam logic [11:0] MASK_SELECT_LOW_OFS = 12'h0_040;
	localparam logic [11:0] MASK_SET_BASE = 12'h0_050;
	localparam logic [11:0] PAIR_CONTROL_BASE = 12'h0_060;
	localparam logic [11:0] IRQ_STATUS_OFS = 12'h0_080;
	localparam logic [11:0] IRQ_MASK_OFS = 12'h0_084;
	localparam logic [11:0] MATCH_STATUS_OFS = 12'h0_088;
	localparam logic [15:0] MASK_SELECT_RESET = 16'h0_000;
	localparam logic [15:0] PAIR_CONTROL_RESET = 16'h0_000;
	localparam logic [15:0] MASK_SET_RESET = 16'h0_000;
	// Mask source encodings.
	localparam logic [1:0] MASK_SRC_SET0 = 2'h0;
	localparam logic [1:0] MASK_SRC_SET1 = 2'h1;
	localparam logic [1:0] MASK_SRC_SET2 = 2'h2;
	localparam logic [1:0] MASK_SRC_RESERVED = 2'h3;
	// Bit positions within one buffer byte.
	localparam int POS_DIRECTION = 7;
	localparam int POS_ABORTED = 6;
	localparam int POS_ARB_LOST = 5;
	localparam int POS_TX_ERROR = 4;
	localparam int POS_SEND_REQUEST = 3;
	localparam int POS_AUTO_REMOTE = 2;
	localparam int POS_PRIO_HI = 1;
	localparam int POS_PRIO_LO = 0;
	// Interrupt status layout: bits 7:0 sent, 15:8 failed, 16 filter hit.
	localparam int IRQ_WIDTH = 17;

	typedef struct packed {
		logic direction;
		logic aborted;
		logic arb_lost;
		logic tx_error;
		logic send_request;
		logic auto_remote;
		logic [1:0] priority_level;
	} buffer_ctrl_t;

	// Outcome reported by the protocol engine for the buffer in flight.
	typedef struct packed {
		logic done;
		logic success;
		logic aborted;
		logic arb_lost;
		logic bus_error;
		logic [2:0] buffer;
	} tx_outcome_t;

	typedef struct packed {
		logic valid;
		logic [ID_WIDTH-1:0] ext_id;
	} rx_id_t;
endpackage

/* File: can_filter_match.sv */
// One acceptance filter compare with its mask source selection.
module can_filter_match (
	input wire logic [can_filt_pkg::ID_WIDTH-1:0] i_ext_id,
	input wire logic [can_filt_pkg::ID_WIDTH-1:0] i_ext_id_match_bits,
	input wire logic [1:0] i_filter_mask_source,
	input wire logic [3*can_filt_pkg::ID_WIDTH-1:0] i_mask_sets,
	output logic o_hit
);
	import can_filt_pkg::*;
	logic [ID_WIDTH-1:0] mask;
	always_comb begin
		unique case (i_filter_mask_source)
			MASK_SRC_SET0: mask = i_mask_sets[ID_WIDTH-1:0];
			MASK_SRC_SET1: mask = i_mask_sets[2*ID_WIDTH-1:ID_WIDTH];
			MASK_SRC_SET2: mask = i_mask_sets[3*ID_WIDTH-1:2*ID_WIDTH];
			default: mask = '0;
		endcase
	end
	assign o_hit = (i_filter_mask_source != MASK_SRC_RESERVED) &&
		(((i_ext_id ^ i_ext_id_match_bits) & mask) == '0);
endmodule // can_filter_match

/* File: can_filter_txbuf_control.sv */
// Acceptance filtering and transmit buffer control with an APB slave.
module can_filter_txbuf_control (
	input wire logic i_clock,
	input wire logic i_srst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire can_filt_pkg::rx_id_t i_rx_id,
	output logic o_rx_accept,
	output logic [3:0] o_rx_filter,
	input wire can_filt_pkg::tx_outcome_t i_tx_outcome,
	input wire logic i_remote_request,
	input wire logic [2:0] i_remote_buffer,
	output logic o_tx_pending,
	output logic [2:0] o_tx_buffer,
	output logic o_tx_abort,
	output logic o_remote_reply,
	output logic o_irq
);
	import can_filt_pkg::*;

	logic [ID_WIDTH-1:0] filter_value_reg [NUM_FILTERS];
	logic [15:0] mask_select_reg;
	logic [3*ID_WIDTH-1:0] mask_sets_reg;
	buffer_ctrl_t buf_reg [NUM_BUFFERS];
	logic [IRQ_WIDTH-1:0] irq_status_reg;
	logic [IRQ_WIDTH-1:0] irq_mask_reg;
	logic [NUM_FILTERS-1:0] hit;
	logic [NUM_FILTERS-1:0] match_status_reg;
	logic wr;
	logic rd;
	logic lane_ok;
	logic [NUM_BUFFERS-1:0] sent_ev;
	logic [NUM_BUFFERS-1:0] fail_ev;

	assign wr = i_psel && i_penable && i_pwrite;
	assign rd = i_psel && i_penable && !i_pwrite;
	assign lane_ok = i_pstrb[0] && i_pstrb[1];
	assign o_pready = 1'b1;

	function automatic logic mapped(input logic [11:0] a);
		mapped = (a[1:0] == 2'b00) &&
			(a < MASK_SELECT_LOW_OFS ||
			a == MASK_SELECT_LOW_OFS ||
			(a >= MASK_SET_BASE && a < MASK_SET_BASE + 12'h0_00c) ||
			(a >= PAIR_CONTROL_BASE && a < PAIR_CONTROL_BASE + 12'h0_010) ||
			a == IRQ_STATUS_OFS || a == IRQ_MASK_OFS ||
			a == MATCH_STATUS_OFS);
	endfunction

	assign o_pslverr = i_psel && i_penable && !mapped(i_paddr);

	always_ff @(posedge i_clock) begin
		if (wr && lane_ok && i_paddr < MASK_SELECT_LOW_OFS)
			filter_value_reg[i_paddr[5:2]] <= i_pwdata[15:0];
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			mask_select_reg <= MASK_SELECT_RESET;
			mask_sets_reg <= {3{MASK_SET_RESET}};
		end else if (wr && lane_ok) begin
			if (i_paddr == MASK_SELECT_LOW_OFS)
				mask_select_reg <= i_pwdata[15:0];
			for (int s = 0; s < 3; s++) begin
				if (i_paddr == MASK_SET_BASE + 12'(4 * s))
					mask_sets_reg[s*ID_WIDTH +: ID_WIDTH] <= i_pwdata[15:0];
			end
		end
	end

	// Filters 8 to 15 have no mask select field here and use mask set 0.
	for (genvar f = 0; f < NUM_FILTERS; f++) begin : g_filter
		logic [1:0] src;
		if (f < 8) begin : g_field
			assign src = mask_select_reg[2*f +: 2];
		end else begin : g_fixed
			assign src = MASK_SRC_SET0;
		end
		can_filter_match u_match (
			.i_ext_id(i_rx_id.ext_id),
			.i_ext_id_match_bits(filter_value_reg[f]),
			.i_filter_mask_source(src),
			.i_mask_sets(mask_sets_reg),
			.o_hit(hit[f])
		);
	end

	// Lowest-numbered hitting filter wins and is reported one cycle later.
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_rx_accept <= 1'b0;
			o_rx_filter <= '0;
			match_status_reg <= '0;
		end else begin
			o_rx_accept <= i_rx_id.valid && (hit != '0);
			if (i_rx_id.valid) begin
				match_status_reg <= hit;
				for (int f = NUM_FILTERS - 1; f >= 0; f--) begin
					if (hit[f])
						o_rx_filter <= 4'(f);
				end
			end
		end
	end

	// Buffer control: even in low byte, odd in high byte.
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			for (int b = 0; b < NUM_BUFFERS; b++)
				buf_reg[b] <= buffer_ctrl_t'(PAIR_CONTROL_RESET[7:0]);
		end else begin
			for (int b = 0; b < NUM_BUFFERS; b++) begin
				automatic logic [7:0] wb = i_pwdata[8*(b%2) +: 8];
				automatic logic hit_wr = wr && i_pstrb[b%2] &&
					i_paddr == PAIR_CONTROL_BASE + 12'(4 * (b / 2));
				if (hit_wr) begin
					buf_reg[b].direction <= wb[POS_DIRECTION];
					buf_reg[b].auto_remote <= wb[POS_AUTO_REMOTE];
					buf_reg[b].priority_level <= wb[POS_PRIO_HI:POS_PRIO_LO];
					buf_reg[b].send_request <= wb[POS_SEND_REQUEST];
					if (wb[POS_SEND_REQUEST] && !buf_reg[b].send_request) begin
						buf_reg[b].aborted <= 1'b0;
						buf_reg[b].arb_lost <= 1'b0;
						buf_reg[b].tx_error <= 1'b0;
					end
				end
				if (i_tx_outcome.done && i_tx_outcome.buffer == 3'(b)) begin
					if (i_tx_outcome.success)
						buf_reg[b].send_request <= 1'b0;
					if (i_tx_outcome.aborted) begin
						buf_reg[b].aborted <= 1'b1;
						buf_reg[b].send_request <= 1'b0;
					end
					if (i_tx_outcome.arb_lost)
						buf_reg[b].arb_lost <= 1'b1;
					if (i_tx_outcome.bus_error)
						buf_reg[b].tx_error <= 1'b1;
				end
				// Auto remote reply queues the buffer.
				if (i_remote_request && i_remote_buffer == 3'(b) &&
					buf_reg[b].direction && buf_reg[b].auto_remote)
					buf_reg[b].send_request <= 1'b1;
			end
		end
	end

	// Priority selection, lower index breaks ties.
	always_comb begin
		automatic logic [1:0] best = '0;
		o_tx_pending = 1'b0;
		o_tx_buffer = '0;
		for (int b = 0; b < NUM_BUFFERS; b++) begin
			if (buf_reg[b].direction && buf_reg[b].send_request &&
				(!o_tx_pending || buf_reg[b].priority_level > best)) begin
				o_tx_pending = 1'b1;
				o_tx_buffer = 3'(b);
				best = buf_reg[b].priority_level;
			end
		end
	end

	// Clearing a pending request asks for abort.
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_tx_abort <= 1'b0;
			o_remote_reply <= 1'b0;
		end else begin
			o_tx_abort <= 1'b0;
			for (int b = 0; b < NUM_BUFFERS; b++) begin
				if (wr && i_pstrb[b%2] && buf_reg[b].send_request &&
					i_paddr == PAIR_CONTROL_BASE + 12'(4 * (b / 2)) &&
					!i_pwdata[8*(b%2) + POS_SEND_REQUEST])
					o_tx_abort <= 1'b1;
			end
			o_remote_reply <= i_remote_request &&
				buf_reg[i_remote_buffer].direction &&
				buf_reg[i_remote_buffer].auto_remote;
		end
	end

	always_comb begin
		for (int b = 0; b < NUM_BUFFERS; b++) begin
			sent_ev[b] = i_tx_outcome.done && i_tx_outcome.success &&
				i_tx_outcome.buffer == 3'(b);
			fail_ev[b] = i_tx_outcome.done && !i_tx_outcome.success &&
				i_tx_outcome.buffer == 3'(b);
		end
	end

	// Sticky status, set wins over write-one-to-clear.
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			irq_status_reg <= '0;
			irq_mask_reg <= '0;
		end else begin
			automatic logic [IRQ_WIDTH-1:0] clr = '0;
			if (wr && i_paddr == IRQ_STATUS_OFS)
				clr = i_pwdata[IRQ_WIDTH-1:0];
			if (wr && i_paddr == IRQ_MASK_OFS)
				irq_mask_reg <= i_pwdata[IRQ_WIDTH-1:0];
			irq_status_reg <= (irq_status_reg & ~clr) |
				{o_rx_accept, fail_ev, sent_ev};
		end
	end

	assign o_irq = |(irq_status_reg & irq_mask_reg);

	// Read data registered in the setup phase, before the access edge.
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_prdata <= '0;
		end else if (i_psel && !i_penable && !i_pwrite) begin
			o_prdata <= '0;
			if (i_paddr < MASK_SELECT_LOW_OFS)
				o_prdata <= {16'h0_000, filter_value_reg[i_paddr[5:2]]};
			else if (i_paddr == MASK_SELECT_LOW_OFS)
				o_prdata <= {16'h0_000, mask_select_reg};
			else if (i_paddr == IRQ_STATUS_OFS)
				o_prdata <= 32'(irq_status_reg);
			else if (i_paddr == IRQ_MASK_OFS)
				o_prdata <= 32'(irq_mask_reg);
			else if (i_paddr == MATCH_STATUS_OFS)
				o_prdata <= 32'(match_status_reg);
			for (int s = 0; s < 3; s++) begin
				if (i_paddr == MASK_SET_BASE + 12'(4 * s))
					o_prdata <= {16'h0_000, mask_sets_reg[s*ID_WIDTH +: ID_WIDTH]};
			end
			for (int p = 0; p < NUM_PAIRS; p++) begin
				if (i_paddr == PAIR_CONTROL_BASE + 12'(4 * p))
					o_prdata <= {16'h0_000, buf_reg[2*p+1], buf_reg[2*p]};
			end
		end
	end

	// Flags clear after a fresh request.
	sequence s_fresh_request;
		$rose(buf_reg[0].send_request) && !$past(i_tx_outcome.done);
	endsequence
	AST_REQ_CLEARS: assert property (
		@(posedge i_clock) disable iff (i_srst)
		s_fresh_request |-> !buf_reg[0].aborted && !buf_reg[0].arb_lost &&
		!buf_reg[0].tx_error)
		else $error("flags not cleared by send request");
	AST_ABORT_SETS: assert property (
		@(posedge i_clock) disable iff (i_srst)
		i_tx_outcome.done && i_tx_outcome.aborted
		|=> buf_reg[$past(i_tx_outcome.buffer)].aborted)
		else $error("aborted flag not set");
	// Aborted flag rises only on an abort.
	AST_ABORT_ONLY: assert property (
		@(posedge i_clock) disable iff (i_srst)
		$rose(buf_reg[0].aborted) |-> $past(i_tx_outcome.done) &&
		$past(i_tx_outcome.aborted) && $past(i_tx_outcome.buffer) == 3'h0)
		else $error("aborted flag set without abort");
	AST_ARB_SETS: assert property (
		@(posedge i_clock) disable iff (i_srst)
		i_tx_outcome.done && i_tx_outcome.arb_lost
		|=> buf_reg[$past(i_tx_outcome.buffer)].arb_lost)
		else $error("arbitration lost flag not set");
	// Arbitration flag rises only on a loss.
	AST_ARB_ONLY: assert property (
		@(posedge i_clock) disable iff (i_srst)
		$rose(buf_reg[0].arb_lost) |-> $past(i_tx_outcome.done) &&
		$past(i_tx_outcome.arb_lost) && $past(i_tx_outcome.buffer) == 3'h0)
		else $error("arbitration flag set without loss");
	AST_ERR_SETS: assert property (
		@(posedge i_clock) disable iff (i_srst)
		i_tx_outcome.done && i_tx_outcome.bus_error
		|=> buf_reg[$past(i_tx_outcome.buffer)].tx_error)
		else $error("error flag not set");
	AST_SUCCESS_CLEARS: assert property (
		@(posedge i_clock) disable iff (i_srst)
		i_tx_outcome.done && i_tx_outcome.success && !i_remote_request && !wr
		|=> !buf_reg[$past(i_tx_outcome.buffer)].send_request)
		else $error("send request not cleared");
	// Clearing a pending request asks for abort.
	sequence s_pending_cleared;
		wr && i_pstrb[0] && i_paddr == PAIR_CONTROL_BASE &&
		buf_reg[0].send_request && !i_pwdata[POS_SEND_REQUEST];
	endsequence
	AST_ABORT_REQ: assert property (
		@(posedge i_clock) disable iff (i_srst)
		s_pending_cleared |=> o_tx_abort)
		else $error("abort not requested");
	AST_ACCEPT: assert property (
		@(posedge i_clock) disable iff (i_srst)
		i_rx_id.valid && hit[0] |=> o_rx_accept && o_rx_filter == 4'h0)
		else $error("matching id not accepted");
	// Accept only follows a received id.
	AST_RX_PULSE: assert property (
		@(posedge i_clock) disable iff (i_srst)
		o_rx_accept |-> $past(i_rx_id.valid))
		else $error("accept without received id");
	AST_RESERVED: assert property (
		@(posedge i_clock) disable iff (i_srst)
		mask_select_reg[7:6] == MASK_SRC_RESERVED |-> !hit[3])
		else $error("reserved mask source matched");
	// Chosen buffer is pending and not outranked by buffer 1.
	AST_PRIO: assert property (
		@(posedge i_clock) disable iff (i_srst)
		o_tx_pending |-> buf_reg[o_tx_buffer].send_request &&
		buf_reg[o_tx_buffer].direction &&
		!(buf_reg[1].direction && buf_reg[1].send_request &&
		buf_reg[1].priority_level > buf_reg[o_tx_buffer].priority_level))
		else $error("selected buffer not pending or outranked");
	// Remote frame queues an armed transmit buffer.
	sequence s_remote_armed;
		i_remote_request && buf_reg[i_remote_buffer].direction &&
		buf_reg[i_remote_buffer].auto_remote;
	endsequence
	AST_REMOTE: assert property (
		@(posedge i_clock) disable iff (i_srst)
		s_remote_armed |=> o_remote_reply &&
		buf_reg[$past(i_remote_buffer)].send_request)
		else $error("remote frame not answered");
	AST_DIR: assert property (
		@(posedge i_clock) disable iff (i_srst)
		!buf_reg[0].direction && !buf_reg[1].direction && o_tx_pending
		|-> o_tx_buffer > 3'h1)
		else $error("receive buffer offered for send");
	// Sent status is set even when a clear lands in the same cycle.
	AST_STICKY_SET: assert property (
		@(posedge i_clock) disable iff (i_srst)
		sent_ev[1] |=> irq_status_reg[1])
		else $error("sent status not set");
endmodule // can_filter_txbuf_control

/* File: can_engine_model.sv */
// Behavioural protocol engine that reports transmit outcomes.
module can_engine_model (
	input wire logic i_clock,
	input wire logic i_srst,
	input wire logic i_arm,
	input wire logic [1:0] i_kind,
	input wire logic [3:0] i_delay,
	input wire logic [2:0] i_tx_buffer,
	output can_filt_pkg::tx_outcome_t o_outcome
);
	timeunit 1ns;
	timeprecision 1ps;
	import can_filt_pkg::*;
	logic busy_reg;
	logic [3:0] cnt_reg;
	logic [2:0] buf_reg;
	logic [1:0] kind_reg;
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			busy_reg <= 1'h0;
			cnt_reg <= 4'h0;
			buf_reg <= 3'h0;
			kind_reg <= 2'h0;
			o_outcome <= '0;
		end else begin
			// Idle buffer field is scrambled so a stale value is never trusted.
			o_outcome <= {5'h00, ~buf_reg};
			if (i_arm) begin
				busy_reg <= 1'h1;
				cnt_reg <= i_delay;
				buf_reg <= i_tx_buffer;
				kind_reg <= i_kind;
			end else if (busy_reg && cnt_reg == 4'h0) begin
				busy_reg <= 1'h0;
				o_outcome <= {1'h1, kind_reg == 2'h0, kind_reg == 2'h1,
					kind_reg == 2'h2, kind_reg == 2'h3, buf_reg};
			end else if (busy_reg) begin
				cnt_reg <= cnt_reg - 4'h1;
			end
		end
	end
endmodule // can_engine_model

/* File: testbench.sv */
// Self-checking testbench for the filter and buffer control block.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import can_filt_pkg::*;
	logic clock = 1'h0;
	logic srst = 1'h1;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err_seen;
	rx_id_t rx_id = '0;
	tx_outcome_t outcome;
	logic remote_req = 1'h0;
	logic [2:0] remote_buf = 3'h0;
	logic arm = 1'h0;
	logic [1:0] kind = 2'h0;
	logic [3:0] delay = 4'h0;
	logic rx_accept, tx_pending, tx_abort, remote_reply, irq;
	logic [3:0] rx_filter;
	logic [2:0] tx_buffer;
	int n_fail = 0;
	int cmp_count = 0;
	always #5 clock = ~clock;
	can_filter_txbuf_control i_can_filter_txbuf_control (.i_clock(clock),
		.i_srst(srst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hf), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_rx_id(rx_id),
		.o_rx_accept(rx_accept), .o_rx_filter(rx_filter),
		.i_tx_outcome(outcome), .i_remote_request(remote_req),
		.i_remote_buffer(remote_buf), .o_tx_pending(tx_pending),
		.o_tx_buffer(tx_buffer), .o_tx_abort(tx_abort),
		.o_remote_reply(remote_reply), .o_irq(irq));
	can_engine_model i_can_engine_model (.i_clock(clock), .i_srst(srst),
		.i_arm(arm), .i_kind(kind), .i_delay(delay), .i_tx_buffer(tx_buffer),
		.o_outcome(outcome));
	task complete_run;
		if (n_fail == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'h1 && n < 50);
		if (n >= 50) n_fail++;
		rd = prdata;
		err_seen = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clock);
	endtask
	task rd_chk(input string s, input logic [11:0] a, input logic [31:0] m,
		input logic [31:0] e);
		apb(1'h0, a, 32'h0000_0000);
		chk(s, e, rd & m);
	endtask
	task rx(input logic [15:0] id, input logic acc, input logic [3:0] f);
		rx_id <= '{1'h1, id};
		@(posedge clock);
		rx_id.valid <= 1'h0;
		#1;
		chk("accept", {31'h0, acc}, {31'h0, rx_accept});
		if (acc) chk("filter", {28'h0, f}, {28'h0, rx_filter});
		@(posedge clock);
	endtask
	task send(input logic [1:0] k, input logic [3:0] dl, input logic wr,
		input logic [31:0] wd);
		int n;
		kind <= k;
		delay <= dl;
		arm <= 1'h1;
		@(posedge clock);
		arm <= 1'h0;
		if (wr) begin
			apb(1'h1, PAIR_CONTROL_BASE, wd);
			// The abort pulse still stands as this edge is sampled.
			chk("abort", 32'h1, {31'h0, tx_abort});
		end
		n = 0;
		while (outcome.done !== 1'h1 && n < 40) begin
			@(posedge clock);
			n++;
		end
		if (n >= 40) n_fail++;
		repeat (2) @(posedge clock);
	endtask
	initial begin
		repeat (20000) @(posedge clock);
		n_fail++;
		complete_run;
	end
	initial begin
		repeat (4) @(posedge clock);
		srst <= 1'h0;
		rd_chk("msel", MASK_SELECT_LOW_OFS, 32'hffff_ffff, 32'h0);
		rd_chk("pair", PAIR_CONTROL_BASE, 32'hffff_ffff, 32'h0);
		apb(1'h0, 12'h0fc, 32'h0000_0000);
		chk("slverr", 32'h1, {31'h0, err_seen});
		for (int i = 0; i < 16; i++)
			apb(1'h1, FILTER_VALUE_BASE + 12'(4 * i), 32'h0000_c000 | 32'(i));
		apb(1'h1, 12'h004, 32'h0000_5500);
		apb(1'h1, 12'h008, 32'h0000_0066);
		apb(1'h1, 12'h00c, 32'h0000_7777);
		rd_chk("fval", 12'h004, 32'hffff_ffff, 32'h0000_5500);
		apb(1'h1, MASK_SET_BASE, 32'h0000_ffff);
		apb(1'h1, MASK_SET_BASE + 12'h004, 32'h0000_ff00);
		apb(1'h1, MASK_SET_BASE + 12'h008, 32'h0000_00ff);
		apb(1'h1, MASK_SELECT_LOW_OFS, 32'h0000_40e4);
		rd_chk("msel", MASK_SELECT_LOW_OFS, 32'hffff, 32'h40e4);
		rx(16'h55ab, 1'h1, 4'h1);
		rx(16'h1166, 1'h1, 4'h2);
		rx(16'h7777, 1'h0, 4'h0);
		rx(16'hc0ff, 1'h1, 4'h7);
		rx(16'hc005, 1'h1, 4'h5);
		rd_chk("match", MATCH_STATUS_OFS, 32'hffff_ffff, 32'h0000_00a0);
		rx(16'hc105, 1'h0, 4'h0);
		apb(1'h1, PAIR_CONTROL_BASE, 32'h0000_8b89);
		chk("tx", 32'h9, {28'h0, tx_pending, tx_buffer});
		send(2'h0, 4'h0, 1'h0, 32'h0);
		rd_chk("pair", PAIR_CONTROL_BASE, 32'hffff, 32'h8389);
		chk("tx", 32'h8, {28'h0, tx_pending, tx_buffer});
		send(2'h1, 4'h9, 1'h1, 32'h0000_8381);
		rd_chk("pair", PAIR_CONTROL_BASE, 32'hff, 32'hc1);
		apb(1'h1, PAIR_CONTROL_BASE, 32'h0000_8389);
		rd_chk("pair", PAIR_CONTROL_BASE, 32'hff, 32'h89);
		send(2'h2, 4'h3, 1'h0, 32'h0);
		rd_chk("arb", PAIR_CONTROL_BASE, 32'h70, 32'h20);
		apb(1'h1, PAIR_CONTROL_BASE, 32'h0000_8381);
		apb(1'h1, PAIR_CONTROL_BASE, 32'h0000_8389);
		send(2'h3, 4'h0, 1'h0, 32'h0);
		rd_chk("err", PAIR_CONTROL_BASE, 32'h70, 32'h10);
		apb(1'h1, PAIR_CONTROL_BASE + 12'h004, 32'h0000_7070);
		rd_chk("ro", PAIR_CONTROL_BASE + 12'h004, 32'hffff, 32'h0);
		apb(1'h1, PAIR_CONTROL_BASE, 32'h0000_8381);
		apb(1'h1, PAIR_CONTROL_BASE, 32'h0000_8389);
		apb(1'h1, PAIR_CONTROL_BASE + 12'h004, 32'h0000_000b);
		chk("tx", 32'h8, {28'h0, tx_pending, tx_buffer});
		apb(1'h1, PAIR_CONTROL_BASE + 12'h004, 32'h0000_0084);
		for (int b = 2; b < 4; b++) begin
			remote_req <= 1'h1;
			remote_buf <= 3'(b);
			@(posedge clock);
			remote_req <= 1'h0;
			#1 chk("reply", {31'h0, b == 2}, {31'h0, remote_reply});
			@(posedge clock);
		end
		rd_chk("irqst", IRQ_STATUS_OFS, 32'hffff_ffff, 32'h0001_0102);
		chk("irq", 32'h0, {31'h0, irq});
		apb(1'h1, IRQ_MASK_OFS, 32'h0000_0100);
		chk("irq", 32'h1, {31'h0, irq});
		apb(1'h1, IRQ_STATUS_OFS, 32'h0000_0100);
		chk("irq", 32'h0, {31'h0, irq});
		rd_chk("irqst", IRQ_STATUS_OFS, 32'hffff_ffff, 32'h0001_0002);
		complete_run;
	end
endmodule // testbench
